// [design/ntb_bar_window_setup.sv]
`timescale 1ns/1ps
// Summary of operation
// - Setup bits 9:4 give window size in address bits, span two to size.
// - Size zero means full 64-bit space; every base bit writable.
// - Base field bit zero maps to bus address bit 4 upward.
// - Size four and up: base bits at/above size writable, lower bits read zero.
// - Size one to three makes the whole base field read-only zero.
// - Setup bit 31 enables window; when clear base register reads zero.
// - Setup bits 30:10 are reserved and read zero.
// - BAR2 64-bit memory: BAR3 translation is full 32-bit upper half.
// - BAR3 translation base in bits 31:4, bits 3:0 read zero.
// - Translation replaces bits 31 down to size with translated base bits.
// - BAR4 setup fixes memory, 32-bit, non-prefetchable as zero.
// - BAR4 size reads 0xC fixed; only enable writable.
// - Tunnel control bits 7:2 hold register number, bits 1:0 zero.
// - Tunnel control bits 11:8 hold extended register number.
// - Sticky fields survive hot resets; the power-on reset presetn clears every field.
// - BAR2 64-bit memory: BAR3 setup reads zero and is read-only.
module ntb_bar_window_setup
    import ntb_bar_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Address translation path
    input  wire logic [31:0] xlat_in_addr,
    output logic      [31:0] xlat_out_addr,
    output logic             bar3_hit,
    output logic             bar4_hit,
    output logic             bar2_wide_mode,
    output logic      [31:0] bar2_xlat_upper
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic        b2_space;
        logic [1:0]  b2_type;
        logic        b2_early;
        logic [5:0]  b2_size;
        logic        b2_en;
        logic        b3_space;
        logic [1:0]  b3_type;
        logic        b3_early;
        logic [5:0]  b3_size;
        logic        b3_en;
        logic [31:0] b3_xlat;
        logic        b4_en;
        logic [9:0]  tun;
        logic [27:0] b3_base;
        logic [27:0] b4_base;
        logic [31:0] rdata;
        logic [31:0] xaddr;
        logic        hit3;
        logic        hit4;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Bits of base_addr_field that software may change for a size
    function automatic logic [31:0] base_mask(input logic [5:0] size);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = BASE_LSB; i < 32; i++) begin
            if (size == RST_SIZE) begin
                m[i] = 1'b1;
            end else if (size >= SIZE_MIN_ON && 6'(i) >= size) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Bits taken from the translated base (31 down to size)
    // Bits 3:0 always pass, since the translated base starts at bit 4
    function automatic logic [31:0] xlat_mask(input logic [5:0] size);
        logic [31:0] m;
        m = 32'h0000_0000;
        for (int i = BASE_LSB; i < 32; i++) begin
            if (6'(i) >= size) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    function automatic logic [31:0] strb_mask(input logic [3:0] s);
        return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    endfunction

    logic        wide;
    logic [31:0] m3;
    logic [31:0] m4;
    logic [31:0] b3_word;
    logic [31:0] b4_word;
    logic [31:0] cfg3_rd;
    logic [31:0] cfg2_rd;
    logic [31:0] xl3_rd;
    logic [31:0] rd_mux;
    logic        mapped;
    logic        wr_en;
    logic [31:0] wmask;
    logic [31:0] wval;
    logic [31:0] xm3;

    // ------------------------------------------------------------
    // Decode and readback
    // ------------------------------------------------------------
    always_comb begin
        wide    = (st_r.b2_space == SPACE_MEM) && (st_r.b2_type == TYPE_ADDR64);
        m3      = wide ? 32'h0000_0000 : base_mask(st_r.b3_size);
        m4      = base_mask(BAR4_SIZE);
        b3_word = {st_r.b3_base, 4'h0} & m3;
        b4_word = {st_r.b4_base, 4'h0} & m4;
        cfg2_rd = {st_r.b2_en, 21'h000000, st_r.b2_size, st_r.b2_early,
                   (st_r.b2_space == SPACE_MEM) ? st_r.b2_type : TYPE_ADDR32, st_r.b2_space};
        cfg3_rd = {st_r.b3_en, 21'h000000, st_r.b3_size, st_r.b3_early,
                   (st_r.b3_space == SPACE_MEM) ? st_r.b3_type : TYPE_ADDR32, st_r.b3_space};
        if (wide) begin
            cfg3_rd = 32'h0000_0000;
        end
        xl3_rd = wide ? st_r.b3_xlat : {st_r.b3_xlat[31:4], 4'h0};
        mapped = 1'b1;
        unique case (paddr)
            OFS_BAR2_WINDOW_CFG: rd_mux = cfg2_rd;
            OFS_BAR3_WINDOW_CFG: rd_mux = cfg3_rd;
            OFS_BAR3_XLAT:       rd_mux = xl3_rd;
            OFS_BAR4_WINDOW_CFG: rd_mux = {st_r.b4_en, 21'h000000, BAR4_SIZE, 4'h0};
            OFS_TUNNEL_CFG_CTL:  rd_mux = {20'h00000, st_r.tun, 2'h0};
            OFS_BAR3_BASE:       rd_mux = st_r.b3_en ? b3_word : 32'h0000_0000;
            OFS_BAR4_BASE:       rd_mux = st_r.b4_en ? b4_word : 32'h0000_0000;
            default: begin
                rd_mux = 32'h0000_0000;
                mapped = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        wr_en  = psel && penable && pwrite && mapped;
        wmask  = strb_mask(pstrb);
        wval   = pwdata;
        xm3    = xlat_mask(st_r.b3_size);
        // Read data captured in setup so the access phase needs no wait
        if (psel && !penable) begin
            st_nxt.rdata = rd_mux;
        end
        if (wr_en) begin
            unique case (paddr)
                OFS_BAR2_WINDOW_CFG: begin
                    if (wmask[0]) begin
                        st_nxt.b2_space = wval[SPACE_BIT];
                        st_nxt.b2_type  = wval[TYPE_HI:TYPE_LO];
                        st_nxt.b2_early = wval[EARLY_BIT];
                    end
                    if (wmask[SIZE_LO] && wmask[SIZE_HI]) begin
                        st_nxt.b2_size = wval[SIZE_HI:SIZE_LO];
                    end
                    if (wmask[EN_BIT]) begin
                        st_nxt.b2_en = wval[EN_BIT];
                    end
                end
                OFS_BAR3_WINDOW_CFG: begin
                    if (!wide) begin
                        if (wmask[0]) begin
                            st_nxt.b3_space = wval[SPACE_BIT];
                            st_nxt.b3_type  = wval[TYPE_HI:TYPE_LO];
                            st_nxt.b3_early = wval[EARLY_BIT];
                        end
                        if (wmask[SIZE_LO] && wmask[SIZE_HI]) begin
                            st_nxt.b3_size = wval[SIZE_HI:SIZE_LO];
                        end
                        if (wmask[EN_BIT]) begin
                            st_nxt.b3_en = wval[EN_BIT];
                        end
                    end
                end
                OFS_BAR3_XLAT: begin
                    // Low nibble only writable as upper half of BAR2
                    st_nxt.b3_xlat = (st_r.b3_xlat & ~wmask) | (wval & wmask);
                    if (!wide) begin
                        st_nxt.b3_xlat[3:0] = st_r.b3_xlat[3:0];
                    end
                end
                OFS_BAR4_WINDOW_CFG: begin
                    if (wmask[EN_BIT]) begin
                        st_nxt.b4_en = wval[EN_BIT];
                    end
                end
                OFS_TUNNEL_CFG_CTL: begin
                    if (wmask[0]) begin
                        st_nxt.tun[5:0] = wval[7:TUN_REG_LO];
                    end
                    if (wmask[8]) begin
                        st_nxt.tun[9:6] = wval[TUN_CFG_DWORD_INDEX_HI_HI:8];
                    end
                end
                OFS_BAR3_BASE: begin
                    st_nxt.b3_base = ((st_r.b3_base & ~m3[31:4]) |
                                      (wval[31:4] & m3[31:4] & wmask[31:4])) |
                                     (st_r.b3_base & m3[31:4] & ~wmask[31:4]);
                end
                OFS_BAR4_BASE: begin
                    st_nxt.b4_base = ((st_r.b4_base & ~m4[31:4]) |
                                      (wval[31:4] & m4[31:4] & wmask[31:4])) |
                                     (st_r.b4_base & m4[31:4] & ~wmask[31:4]);
                end
                default: begin
                    st_nxt.rdata = st_nxt.rdata;
                end
            endcase
        end
        // Translation path, one cycle of latency
        st_nxt.hit3 = st_r.b3_en && !wide && (st_r.b3_size >= SIZE_MIN_ON) &&
                      (((xlat_in_addr ^ {st_r.b3_base, 4'h0}) & m3) == 32'h0000_0000) &&
                      (m3 != 32'h0000_0000);
        st_nxt.hit4 = st_r.b4_en &&
                      (((xlat_in_addr ^ {st_r.b4_base, 4'h0}) & m4) == 32'h0000_0000);
        st_nxt.xaddr = (xlat_in_addr & ~xm3) | ({st_r.b3_xlat[31:4], 4'h0} & xm3);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // presetn is the power-on reset; hot resets never reach this block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata          = st_r.rdata;
    assign pready          = 1'b1;
    assign pslverr         = psel && penable && !mapped;
    assign xlat_out_addr   = st_r.xaddr;
    assign bar3_hit        = st_r.hit3;
    assign bar4_hit        = st_r.hit4;
    assign bar2_wide_mode  = wide;
    assign bar2_xlat_upper = wide ? st_r.b3_xlat : RST_WORD;

endmodule

// [design/ntb_bar_pkg.sv]
package ntb_bar_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_BAR2_WINDOW_CFG = 12'h088;
    localparam logic [11:0] OFS_BAR3_WINDOW_CFG = 12'h094;
    localparam logic [11:0] OFS_BAR3_XLAT       = 12'h098;
    localparam logic [11:0] OFS_BAR4_WINDOW_CFG = 12'h09c;
    localparam logic [11:0] OFS_TUNNEL_CFG_CTL  = 12'h0a0;
    localparam logic [11:0] OFS_BAR3_BASE       = 12'h0b0;
    localparam logic [11:0] OFS_BAR4_BASE       = 12'h0b4;

    // ------------------------------------------------------------
    // Window setup field layout
    // ------------------------------------------------------------
    localparam int SPACE_BIT   = 0;
    localparam int TYPE_LO     = 1;
    localparam int TYPE_HI     = 2;
    localparam int EARLY_BIT   = 3;
    localparam int SIZE_LO     = 4;
    localparam int SIZE_HI     = 9;
    localparam int EN_BIT      = 31;
    localparam int BASE_LSB    = 4;
    localparam int TUN_REG_LO  = 2;
    localparam int TUN_CFG_DWORD_INDEX_HI_HI = 11;

    // ------------------------------------------------------------
    // Encodings and fixed values
    // ------------------------------------------------------------
    localparam logic [1:0] TYPE_ADDR32  = 2'h0;
    localparam logic [1:0] TYPE_ADDR64  = 2'h2;
    localparam logic       SPACE_MEM    = 1'h0;
    localparam logic [5:0] SIZE_MIN_ON  = 6'h04;
    localparam logic [5:0] BAR4_SIZE    = 6'h0c;

    // ------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [5:0]  RST_SIZE = 6'h00;

endpackage

// [verification/ntb_bar_props.sv]
`timescale 1ns/1ps
module ntb_bar_props
    import ntb_bar_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    // Translation path
    input wire logic [31:0] xlat_in_addr,
    input wire logic [31:0] xlat_out_addr,
    input wire logic        bar2_wide_mode,
    input wire logic [31:0] bar2_xlat_upper
);
    // ----------------------------------------
    // Read access and translation output checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic rd;
    assign rd = psel && penable && !pwrite;
    a_cfg_rsvd_zero: assert property (rd && paddr == OFS_BAR3_WINDOW_CFG |-> prdata[30:10] == 21'h0)
        else $error("setup reserved bits set");
    a_bar4_fixed: assert property (rd && paddr == OFS_BAR4_WINDOW_CFG |-> prdata[30:0] == 31'h0c0)
        else $error("bar4 setup fixed fields wrong");
    a_tun_zero: assert property (rd && paddr == OFS_TUNNEL_CFG_CTL |-> prdata[1:0] == 2'h0)
        else $error("tunnel low bits set");
    a_xlat_low: assert property (rd && paddr == OFS_BAR3_XLAT && !bar2_wide_mode |-> prdata[3:0] == 4'h0)
        else $error("xlat low bits set");
    a_base_low: assert property (rd && paddr == OFS_BAR3_BASE |-> prdata[3:0] == 4'h0)
        else $error("base low bits set");
    a_bar4_base: assert property (rd && paddr == OFS_BAR4_BASE |-> prdata[11:0] == 12'h0)
        else $error("bar4 base below size set");
    a_wide_cfg: assert property (rd && paddr == OFS_BAR3_WINDOW_CFG && bar2_wide_mode |-> prdata == 32'h0)
        else $error("bar3 setup nonzero in wide mode");
    a_upper_off: assert property (!bar2_wide_mode |-> bar2_xlat_upper == 32'h0)
        else $error("upper half shown outside wide mode");
    a_low_pass: assert property ($past(presetn) |-> xlat_out_addr[3:0] == $past(xlat_in_addr[3:0]))
        else $error("low address bits not passed");
endmodule
bind ntb_bar_window_setup ntb_bar_props ntb_bar_props_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .xlat_in_addr(xlat_in_addr),
    .xlat_out_addr(xlat_out_addr), .bar2_wide_mode(bar2_wide_mode), .bar2_xlat_upper(bar2_xlat_upper));

// [verification/xlat_path_model.sv]
`timescale 1ns/1ps
module xlat_path_model (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Bench request and path to block
    input  wire logic [31:0] req_addr,
    output logic      [31:0] xlat_in_addr
);
    // Launched on the edge, as the decode path does
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xlat_in_addr <= 32'h0;
        end else begin
            xlat_in_addr <= req_addr;
        end
    end
endmodule

// [verification/ntb_bar_window_setup_test.sv]
`timescale 1ns/1ps
module ntb_bar_window_setup_test;
    import ntb_bar_pkg::*;
    // ----------------------------------------
    // Signals and instances
    // ----------------------------------------
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, xo, xi, up, req = 32'h0, r;
    logic [3:0]  pstrb = 4'h0;
    logic        h3, h4, wm, e;
    int          err_total = 0, check_count = 0;
    logic [11:0] regs [6] = '{OFS_BAR2_WINDOW_CFG, OFS_BAR3_WINDOW_CFG, OFS_BAR3_XLAT,
                              OFS_TUNNEL_CFG_CTL, OFS_BAR3_BASE, OFS_BAR4_BASE};
    ntb_bar_window_setup ntb_bar_window_setup_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .xlat_in_addr(xi), .xlat_out_addr(xo), .bar3_hit(h3),
        .bar4_hit(h4), .bar2_wide_mode(wm), .bar2_xlat_upper(up));
    xlat_path_model xlat_path_model_inst (.pclk(pclk), .presetn(presetn), .req_addr(req), .xlat_in_addr(xi));
    initial forever #20 pclk = ~pclk;
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic final_report;
        $display("Checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // Idle cycle after each transfer keeps every strobe single-driven per step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        if (n >= 20) begin
            err_total++;
            final_report();
        end
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        apb(1'b1, a, d, s);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(r, x);
    endtask
    task automatic xl(input logic [31:0] a);
        req <= a;
        repeat (3) @(posedge pclk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        foreach (regs[i]) rc(regs[i], 32'h0);
        rc(OFS_BAR4_WINDOW_CFG, 32'h0000_00c0);
        wr(OFS_TUNNEL_CFG_CTL, 32'hffff_ffff);
        rc(OFS_TUNNEL_CFG_CTL, 32'h0000_0ffc);
        wr(OFS_TUNNEL_CFG_CTL, 32'h0, 4'h1);
        rc(OFS_TUNNEL_CFG_CTL, 32'h0000_0f00);
        // Size 8 keeps the memory window above the 16 byte floor
        wr(OFS_BAR3_WINDOW_CFG, 32'hffff_fc88);
        rc(OFS_BAR3_WINDOW_CFG, 32'h8000_0088);
        wr(OFS_BAR3_BASE, 32'hffff_ffff);
        rc(OFS_BAR3_BASE, 32'hffff_ff00);
        wr(OFS_BAR3_WINDOW_CFG, 32'h8000_0020);
        wr(OFS_BAR3_BASE, 32'hffff_ffff);
        rc(OFS_BAR3_BASE, 32'h0);
        wr(OFS_BAR3_WINDOW_CFG, 32'h8000_0000);
        wr(OFS_BAR3_BASE, 32'hffff_ffff);
        rc(OFS_BAR3_BASE, 32'hffff_fff0);
        wr(OFS_BAR3_WINDOW_CFG, 32'h0000_0080);
        rc(OFS_BAR3_BASE, 32'h0);
        wr(OFS_BAR3_WINDOW_CFG, 32'h8000_0088);
        wr(OFS_BAR3_BASE, 32'h1234_5600);
        rc(OFS_BAR3_BASE, 32'h1234_5600);
        wr(OFS_BAR3_XLAT, 32'habcd_ef0f);
        rc(OFS_BAR3_XLAT, 32'habcd_ef00);
        xl(32'h1234_5678);
        chk(xo, 32'habcd_ef78);
        chk({31'h0, h3}, 32'h1);
        xl(32'h1234_7678);
        chk({31'h0, h3}, 32'h0);
        wr(OFS_BAR4_WINDOW_CFG, 32'hffff_ffff);
        rc(OFS_BAR4_WINDOW_CFG, 32'h8000_00c0);
        wr(OFS_BAR4_BASE, 32'hffff_ffff);
        rc(OFS_BAR4_BASE, 32'hffff_f000);
        xl(32'hffff_f123);
        chk({31'h0, h4}, 32'h1);
        apb(1'b0, 12'h0fc, 32'h0, 4'h0);
        chk({31'h0, e}, 32'h1);
        wr(OFS_BAR2_WINDOW_CFG, 32'h0000_0004);
        chk({31'h0, wm}, 32'h1);
        wr(OFS_BAR3_WINDOW_CFG, 32'h8000_0088);
        rc(OFS_BAR3_WINDOW_CFG, 32'h0);
        wr(OFS_BAR3_XLAT, 32'hffff_ffff);
        rc(OFS_BAR3_XLAT, 32'hffff_ffff);
        chk(up, 32'hffff_ffff);
        final_report();
    end
endmodule
